// *** cer_cfg.svh ***
// constants and function summary for the cache error recovery block
// Function
// - L1 tags and L2 copies use parity; a bad copy is fixed from the other.
// - a tag repair that leaves the fault is retried; a lasting fault ends fatal.
// - L2 tag uses SECDED; a correctable fault is rewritten silently.
// - mode bit picks fatal or urgent handling for an uncorrectable L2 tag fault.
// - weak detect 0 and handler flag 0 give an immediate async trap with status.
// - handler flag 1 holds the tag event pending until the flag drops.
// - weak detect 1 ignores the uncorrectable L2 tag fault where possible.
// - instruction L1 holds one parity bit per doubleword; a fetch fault refetches the line.
// - refill stores clean words with good parity, marked words with forced bad parity.
// - a bad-parity instruction that completes traps precisely and logs its mark id.
// - data L1 words use SECDED; correctable faults are fixed silently.
// - a marked word met on writeback goes into L2 unchanged, unreported.
// - a marked word hit by load or non-doubleword store traps and logs its id.
// - a raw word on writeback becomes marked with the identifier register; flag set.
// - a raw word hit by access forces writeback with marking and refill; flag set.
// - a repeated raw fault repeats the sequence until way reduction, then traps marked.
// - L2 words use SECDED; a correctable fill word is fixed, stored, flag set.
// - a correctable L2 read word is fixed in transfer and source, silently.
// - a marked word passes L2 paths unchanged without a report.
// - a raw fill word is marked with id zero and stored; fill flag set.
// - a raw L2 read word is marked with the identifier in copy and source, with id zero when a raw fill word comes in the same cycle.
`ifndef CER_CFG_SVH
`define CER_CFG_SVH
`define CER_MARK_CHK 8'hFF
`define CER_ID_ZERO 12'h000
`define CER_TAG_RETRY_MAX 4'hF
`define CER_TRY_ZERO 4'h0
`define CER_TRY_ONE 4'h1
`define CER_REP_NONE 2'h0
`endif

// *** cer_pkg.sv ***
// types shared by the cache error recovery block
package cer_pkg;
    // outcome of a doubleword check
    typedef enum logic [3:0]
    {
        CER_OK = 4'h1,
        CER_CE = 4'h2,
        CER_MARKED = 4'h4,
        CER_RAW = 4'h8
    } cer_class_t;
    // path an L2 doubleword travels
    typedef enum logic [1:0]
    {
        CER_P_L1FILL = 2'h0,
        CER_P_COPYBACK = 2'h1,
        CER_P_WRITEBACK = 2'h2
    } cer_path_t;
    typedef enum logic [2:0]
    {
        CER_T_IDLE = 3'h1,
        CER_T_COPY = 3'h2,
        CER_T_FATAL = 3'h4
    } cer_tag_st_t;
endpackage

// *** cer_top.sv ***
// cache error recovery: classify, correct, mark and report cache faults
`include "cer_cfg.svh"
module cer_top #(
    parameter int DW = 64,
    parameter int IDW = 12
)(
    input wire logic MCLK,
    input wire logic NRST,
    // mode and controls
    input wire logic INTERNAL_MODE_REGISTER,
    input wire logic WEAK_DETECT_CONTROL,
    input wire logic HANDLER_ACTIVE_FLAG,
    input wire logic [IDW-1:0] ERROR_IDENTIFIER_REGISTER,
    // l1 tag parity
    input wire logic L1_TAG_PERR,
    input wire logic L1_TAG_REPAIR_OK,
    output logic L1_TAG_COPY_REQ,
    // l2 tag ecc
    input wire logic L2_TAG_CE,
    input wire logic L2_TAG_UE,
    output logic L2_TAG_REWRITE,
    output logic FATAL_ERROR,
    output logic ASYNC_DATA_ERROR_TRAP,
    output logic URGENT_ERROR_STATUS,
    // instruction l1: refill word from l2 and fetch
    input wire logic I1_FILL_VALID,
    input wire cer_pkg::cer_class_t I1_FILL_CLASS,
    input wire logic [IDW-1:0] I1_FILL_ID,
    output logic I1_STORE_PARITY_BAD,
    input wire logic I1_FETCH_PERR,
    output logic I1_REFETCH_LINE,
    input wire logic I1_BAD_INSN_COMPLETE,
    input wire logic [IDW-1:0] I1_BAD_INSN_ID,
    output logic INSTR_ACCESS_ERROR_TRAP,
    output logic [IDW-1:0] INSTR_FAULT_STATUS,
    // data l1
    input wire logic D1_CHECK_VALID,
    input wire cer_pkg::cer_class_t D1_CLASS,
    input wire logic D1_IS_WRITEBACK,
    input wire logic D1_IS_DW_STORE,
    input wire logic D1_WAY_REDUCED,
    input wire logic [IDW-1:0] D1_MARK_ID,
    output logic D1_CORRECT,
    output logic D1_WB_MARK,
    output logic [IDW-1:0] D1_WB_MARK_ID,
    output logic D1_FORCE_WB_REFILL,
    output logic DATA_ACCESS_ERROR_TRAP,
    output logic [IDW-1:0] DATA_FAULT_STATUS,
    output logic D1_RAW_ERROR_FLAG,
    // unified l2 data
    input wire logic L2_FILL_VALID,
    input wire cer_pkg::cer_class_t L2_FILL_CLASS,
    input wire logic L2_READ_VALID,
    input wire cer_pkg::cer_class_t L2_READ_CLASS,
    input wire cer_pkg::cer_path_t L2_READ_PATH,
    output logic L2_FILL_CORRECT,
    output logic L2_FILL_MARK,
    output logic L2_READ_CORRECT_BOTH,
    output logic L2_READ_MARK_BOTH,
    output logic [IDW-1:0] L2_MARK_ID,
    output logic [7:0] MARK_CHECK_BITS,
    output logic INCOMING_CORRECTABLE_FLAG,
    output logic L2_FILL_RAW_ERROR_FLAG,
    output logic L2_INTERNAL_RAW_ERROR_FLAG
);
    import cer_pkg::*;

    // ==========================================================
    // l1 tag copy repair
    cer_tag_st_t tst_q, tst_d;
    logic [3:0] tries_q, tries_d;
    wire tag_give_up = (tries_q == `CER_TAG_RETRY_MAX);
    always_comb
    begin
        tst_d = tst_q;
        tries_d = tries_q;
        case (tst_q)
            CER_T_IDLE:
            begin
                if (L1_TAG_PERR)
                begin
                    tst_d = CER_T_COPY;
                    tries_d = `CER_TRY_ZERO;
                end
            end
            CER_T_COPY:
            begin
                if (L1_TAG_REPAIR_OK)
                    tst_d = CER_T_IDLE;
                else if (tag_give_up)
                    tst_d = CER_T_FATAL;
                else
                    tries_d = tries_q + `CER_TRY_ONE;
            end
            CER_T_FATAL: tst_d = CER_T_FATAL;
            default: tst_d = CER_T_IDLE;
        endcase
    end
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            tst_q <= CER_T_IDLE;
            tries_q <= `CER_TRY_ZERO;
        end
        else
        begin
            tst_q <= tst_d;
            tries_q <= tries_d;
        end
    end
    assign L1_TAG_COPY_REQ = (tst_q == CER_T_COPY);

    // ==========================================================
    // l2 tag ecc and urgent event
    wire tag_ue_fatal = L2_TAG_UE && INTERNAL_MODE_REGISTER;
    // weak detect ignores the fault in urgent mode only; the event path stays quiet
    wire tag_ue_event = L2_TAG_UE && !INTERNAL_MODE_REGISTER
        && !WEAK_DETECT_CONTROL;
    logic pend_q, fatal_q, trap_q, ugst_q;
    wire fire = (tag_ue_event || pend_q) && !HANDLER_ACTIVE_FLAG;
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pend_q <= 1'b0;
            fatal_q <= 1'b0;
            trap_q <= 1'b0;
            ugst_q <= 1'b0;
        end
        else
        begin
            pend_q <= (pend_q || tag_ue_event) && HANDLER_ACTIVE_FLAG;
            fatal_q <= fatal_q || tag_ue_fatal || (tst_q == CER_T_FATAL);
            trap_q <= fire;
            ugst_q <= ugst_q || fire;
        end
    end
    assign L2_TAG_REWRITE = L2_TAG_CE && !L2_TAG_UE;
    assign FATAL_ERROR = fatal_q;
    assign ASYNC_DATA_ERROR_TRAP = trap_q;
    assign URGENT_ERROR_STATUS = ugst_q;

    // ==========================================================
    // instruction l1 data
    assign I1_STORE_PARITY_BAD = I1_FILL_VALID && (I1_FILL_CLASS == CER_MARKED);
    assign I1_REFETCH_LINE = I1_FETCH_PERR;
    logic itrap_q;
    logic [IDW-1:0] isfs_q;
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            itrap_q <= 1'b0;
            isfs_q <= `CER_ID_ZERO;
        end
        else
        begin
            // squashed bad fetches never raise complete, so they vanish
            itrap_q <= I1_BAD_INSN_COMPLETE;
            if (I1_BAD_INSN_COMPLETE)
                isfs_q <= I1_BAD_INSN_ID;
        end
    end
    assign INSTR_ACCESS_ERROR_TRAP = itrap_q;
    assign INSTR_FAULT_STATUS = isfs_q;

    // ==========================================================
    // data l1 data
    wire d_raw = D1_CHECK_VALID && (D1_CLASS == CER_RAW);
    wire d_mk = D1_CHECK_VALID && (D1_CLASS == CER_MARKED);
    wire d_raw_wb = d_raw && D1_IS_WRITEBACK;
    // after way reduction a raw hit is handled as marked
    wire d_raw_acc = d_raw && !D1_IS_WRITEBACK && !D1_WAY_REDUCED;
    wire d_mk_acc = (d_mk || (d_raw && D1_WAY_REDUCED)) && !D1_IS_WRITEBACK
        && !D1_IS_DW_STORE;
    logic dtrap_q, d1f_q;
    logic [IDW-1:0] dsfs_q;
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            dtrap_q <= 1'b0;
            dsfs_q <= `CER_ID_ZERO;
            d1f_q <= 1'b0;
        end
        else
        begin
            dtrap_q <= d_mk_acc;
            if (d_mk_acc)
                dsfs_q <= D1_WAY_REDUCED && d_raw ? ERROR_IDENTIFIER_REGISTER : D1_MARK_ID;
            d1f_q <= d_raw_wb || d_raw_acc;
        end
    end
    assign D1_CORRECT = D1_CHECK_VALID && (D1_CLASS == CER_CE);
    assign D1_WB_MARK = d_raw_wb;
    assign D1_WB_MARK_ID = ERROR_IDENTIFIER_REGISTER;
    assign D1_FORCE_WB_REFILL = d_raw_acc;
    assign DATA_ACCESS_ERROR_TRAP = dtrap_q;
    assign DATA_FAULT_STATUS = dsfs_q;
    assign D1_RAW_ERROR_FLAG = d1f_q;

    // ==========================================================
    // unified l2 data
    wire f_ce = L2_FILL_VALID && (L2_FILL_CLASS == CER_CE);
    wire f_raw = L2_FILL_VALID && (L2_FILL_CLASS == CER_RAW);
    wire r_ce = L2_READ_VALID && (L2_READ_CLASS == CER_CE);
    wire r_raw = L2_READ_VALID && (L2_READ_CLASS == CER_RAW);
    logic icf_q, lff_q, lif_q;
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            icf_q <= 1'b0;
            lff_q <= 1'b0;
            lif_q <= 1'b0;
        end
        else
        begin
            icf_q <= f_ce;
            lff_q <= f_raw;
            lif_q <= r_raw && (L2_READ_PATH == CER_P_WRITEBACK);
        end
    end
    // marked words are neither corrected nor flagged anywhere in l2
    assign L2_FILL_CORRECT = f_ce;
    assign L2_FILL_MARK = f_raw;
    assign L2_READ_CORRECT_BOTH = r_ce;
    assign L2_READ_MARK_BOTH = r_raw;
    assign L2_MARK_ID = f_raw ? `CER_ID_ZERO : ERROR_IDENTIFIER_REGISTER;
    // all-ones check field is no valid double-bit syndrome of the code
    assign MARK_CHECK_BITS = `CER_MARK_CHK;
    assign INCOMING_CORRECTABLE_FLAG = icf_q;
    assign L2_FILL_RAW_ERROR_FLAG = lff_q;
    assign L2_INTERNAL_RAW_ERROR_FLAG = lif_q;

    // ==========================================================
    // checks
    property p_tag_retry;
        @(posedge MCLK) disable iff (!NRST)
        (tst_q == CER_T_COPY) && !L1_TAG_REPAIR_OK && !tag_give_up |=> L1_TAG_COPY_REQ;
    endproperty
    a_tag_retry: assert property (p_tag_retry) else $error("tag copy not repeated");
    property p_trap_now;
        @(posedge MCLK) disable iff (!NRST)
        tag_ue_event && !HANDLER_ACTIVE_FLAG |=> ASYNC_DATA_ERROR_TRAP && URGENT_ERROR_STATUS;
    endproperty
    a_trap_now: assert property (p_trap_now) else $error("urgent trap missing");
    property p_pending;
        @(posedge MCLK) disable iff (!NRST)
        pend_q && $fell(HANDLER_ACTIVE_FLAG) |=> ASYNC_DATA_ERROR_TRAP;
    endproperty
    a_pending: assert property (p_pending) else $error("pending event lost");
    property p_weak;
        @(posedge MCLK) disable iff (!NRST)
        WEAK_DETECT_CONTROL && L2_TAG_UE && !pend_q && !HANDLER_ACTIVE_FLAG
            |=> !ASYNC_DATA_ERROR_TRAP;
    endproperty
    a_weak: assert property (p_weak) else $error("weak detect not ignoring");
    property p_itrap;
        @(posedge MCLK) disable iff (!NRST)
        I1_BAD_INSN_COMPLETE |=> INSTR_ACCESS_ERROR_TRAP
            && INSTR_FAULT_STATUS == $past(I1_BAD_INSN_ID);
    endproperty
    a_itrap: assert property (p_itrap) else $error("instruction trap wrong");
    property p_d1flag;
        @(posedge MCLK) disable iff (!NRST)
        D1_WB_MARK |=> D1_RAW_ERROR_FLAG;
    endproperty
    a_d1flag: assert property (p_d1flag) else $error("d1 raw flag missing");
    property p_fillid;
        @(posedge MCLK) disable iff (!NRST)
        L2_FILL_MARK |-> L2_MARK_ID == `CER_ID_ZERO ##1 L2_FILL_RAW_ERROR_FLAG;
    endproperty
    a_fillid: assert property (p_fillid) else $error("fill mark id wrong");
    property p_insd;
        @(posedge MCLK) disable iff (!NRST)
        L2_INTERNAL_RAW_ERROR_FLAG |-> $past(r_raw) && $past(L2_READ_PATH) == CER_P_WRITEBACK;
    endproperty
    a_insd: assert property (p_insd) else $error("internal raw flag off path");
    property p_fatal_mode;
        @(posedge MCLK) disable iff (!NRST)
        L2_TAG_UE && INTERNAL_MODE_REGISTER |=> FATAL_ERROR;
    endproperty
    a_fatal_mode: assert property (p_fatal_mode) else $error("fatal mode not taken");
    property p_tag_fatal;
        @(posedge MCLK) disable iff (!NRST)
        (tst_q == CER_T_COPY) && !L1_TAG_REPAIR_OK && tag_give_up |=> ##1 FATAL_ERROR;
    endproperty
    a_tag_fatal: assert property (p_tag_fatal) else $error("tag fault not fatal");
    property p_d1_refill;
        @(posedge MCLK) disable iff (!NRST)
        D1_CHECK_VALID && D1_CLASS == CER_RAW && !D1_IS_WRITEBACK && !D1_WAY_REDUCED
            |-> D1_FORCE_WB_REFILL ##1 D1_RAW_ERROR_FLAG;
    endproperty
    a_d1_refill: assert property (p_d1_refill) else $error("raw hit not refilled");
    property p_dtrap;
        @(posedge MCLK) disable iff (!NRST)
        D1_CHECK_VALID && D1_CLASS == CER_MARKED && !D1_IS_WRITEBACK && !D1_IS_DW_STORE
            |=> DATA_ACCESS_ERROR_TRAP && DATA_FAULT_STATUS == $past(D1_MARK_ID);
    endproperty
    a_dtrap: assert property (p_dtrap) else $error("marked data trap wrong");
    property p_incoming;
        @(posedge MCLK) disable iff (!NRST)
        L2_FILL_VALID && L2_FILL_CLASS == CER_CE
            |-> L2_FILL_CORRECT ##1 INCOMING_CORRECTABLE_FLAG;
    endproperty
    a_incoming: assert property (p_incoming) else $error("incoming fix not flagged");
endmodule

// *** cer_partner.sv ***
// far-side model: tag copy engine answering repair requests
module cer_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic copy_req,
    input wire logic [4:0] fails,
    output logic repair_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // attempt counter
    logic [4:0] cnt_q;
    // fails of 31 never repairs: a permanent tag fault
    assign repair_ok = copy_req && (cnt_q == fails) && (fails != 5'h1F);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 5'h00;
        else if (!copy_req)
            cnt_q <= 5'h00;
        else if (cnt_q != 5'h1F)
            cnt_q <= cnt_q + 5'h01;
    end
endmodule

// *** tb_top.sv ***
// self-checking bench for the cache error recovery block
`include "cer_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cer_pkg::*;
    // ====================
    // signals
    logic MCLK, NRST, INTERNAL_MODE_REGISTER, WEAK_DETECT_CONTROL, HANDLER_ACTIVE_FLAG;
    logic L1_TAG_PERR, L1_TAG_REPAIR_OK, L1_TAG_COPY_REQ, L2_TAG_CE, L2_TAG_UE, L2_TAG_REWRITE;
    logic FATAL_ERROR, ASYNC_DATA_ERROR_TRAP, URGENT_ERROR_STATUS, I1_FILL_VALID;
    logic I1_STORE_PARITY_BAD, I1_FETCH_PERR, I1_REFETCH_LINE, I1_BAD_INSN_COMPLETE;
    logic INSTR_ACCESS_ERROR_TRAP, D1_CHECK_VALID, D1_IS_WRITEBACK, D1_IS_DW_STORE;
    logic D1_WAY_REDUCED, D1_CORRECT, D1_WB_MARK, D1_FORCE_WB_REFILL, DATA_ACCESS_ERROR_TRAP;
    logic D1_RAW_ERROR_FLAG, L2_FILL_VALID, L2_READ_VALID, L2_FILL_CORRECT, L2_FILL_MARK;
    logic L2_READ_CORRECT_BOTH, L2_READ_MARK_BOTH, INCOMING_CORRECTABLE_FLAG;
    logic L2_FILL_RAW_ERROR_FLAG, L2_INTERNAL_RAW_ERROR_FLAG;
    logic [11:0] ERROR_IDENTIFIER_REGISTER, I1_FILL_ID, I1_BAD_INSN_ID, INSTR_FAULT_STATUS;
    logic [11:0] D1_MARK_ID, D1_WB_MARK_ID, DATA_FAULT_STATUS, L2_MARK_ID, rid;
    logic [7:0] MARK_CHECK_BITS;
    cer_class_t I1_FILL_CLASS, D1_CLASS, L2_FILL_CLASS, L2_READ_CLASS;
    cer_path_t L2_READ_PATH;
    logic [4:0] fails;
    logic [18:0] expq[$];
    logic [18:0] got;
    int err_total, check_count;
    wire [9:0] cv = {L2_TAG_REWRITE, I1_STORE_PARITY_BAD, I1_REFETCH_LINE, D1_CORRECT,
        D1_WB_MARK, D1_FORCE_WB_REFILL, L2_FILL_CORRECT, L2_FILL_MARK, L2_READ_CORRECT_BOTH,
        L2_READ_MARK_BOTH};
    wire [6:0] ev = {ASYNC_DATA_ERROR_TRAP, INSTR_ACCESS_ERROR_TRAP, DATA_ACCESS_ERROR_TRAP,
        D1_RAW_ERROR_FLAG, INCOMING_CORRECTABLE_FLAG, L2_FILL_RAW_ERROR_FLAG,
        L2_INTERNAL_RAW_ERROR_FLAG};
    cer_top cer_top_inst (.*);
    cer_partner cer_partner_inst (.clk(MCLK), .rst_n(NRST), .copy_req(L1_TAG_COPY_REQ),
        .fails(fails), .repair_ok(L1_TAG_REPAIR_OK));
    initial
    begin
        MCLK = 1'h0;
        forever #12.5 MCLK = ~MCLK;
    end
    // ====================
    // helpers
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'h1)
        begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rst();
        NRST = 1'h0;
        repeat (10) @(negedge MCLK);
        NRST = 1'h1;
        @(negedge MCLK);
    endtask
    task automatic clr();
        {L1_TAG_PERR, L2_TAG_CE, L2_TAG_UE, I1_FILL_VALID, I1_FETCH_PERR} = '0;
        {I1_BAD_INSN_COMPLETE, D1_CHECK_VALID, D1_IS_WRITEBACK, D1_IS_DW_STORE} = '0;
        {D1_WAY_REDUCED, L2_FILL_VALID, L2_READ_VALID} = '0;
        I1_FILL_CLASS = CER_OK;
        D1_CLASS = CER_OK;
        L2_FILL_CLASS = CER_OK;
        L2_READ_CLASS = CER_OK;
        L2_READ_PATH = CER_P_L1FILL;
    endtask
    // one doubleword op: note events, check same-cycle outputs, idle a cycle
    task automatic fin(input logic [9:0] e, input logic [6:0] v, input logic [11:0] st, mid);
        if (v != 7'h00)
            expq.push_back({v, st});
        #1;
        chk(cv === e, "comb outputs");
        if (e[5] | e[2] | e[0])
        begin
            chk((e[5] ? D1_WB_MARK_ID : L2_MARK_ID) === mid, "mark id");
            chk(MARK_CHECK_BITS === `CER_MARK_CHK, "mark bits");
        end
        @(negedge MCLK);
        clr();
        @(negedge MCLK);
    endtask
    // ====================
    // monitor: registered events come back in issue order
    always @(negedge MCLK)
    begin
        if (NRST === 1'h1 && ev !== 7'h00)
        begin
            got = {ev, ev[5] ? INSTR_FAULT_STATUS : ev[4] ? DATA_FAULT_STATUS : 12'h000};
            chk(expq.size() != 0, "unexpected event");
            if (expq.size() != 0)
                chk(got === expq.pop_front(), "event or status");
        end
    end
    initial
    begin
        #100000;
        err_total++;
        finish_test();
    end
    // ====================
    // tests
    initial
    begin
        void'($urandom(35));
        {INTERNAL_MODE_REGISTER, WEAK_DETECT_CONTROL, HANDLER_ACTIVE_FLAG} = '0;
        {I1_FILL_ID, I1_BAD_INSN_ID, D1_MARK_ID} = '0;
        fails = 5'h03;
        ERROR_IDENTIFIER_REGISTER = 12'($urandom);
        clr();
        rst();
        L2_TAG_CE = 1'h1;
        fin(10'h200, 7'h00, 12'h000, 12'h000); // silent rewrite
        L2_TAG_UE = 1'h1;
        fin(10'h000, 7'h40, 12'h000, 12'h000); // urgent path
        chk(URGENT_ERROR_STATUS === 1'h1, "urgent status");
        HANDLER_ACTIVE_FLAG = 1'h1;
        L2_TAG_UE = 1'h1;
        fin(10'h000, 7'h00, 12'h000, 12'h000); // held pending
        repeat (3) @(negedge MCLK);
        HANDLER_ACTIVE_FLAG = 1'h0;
        expq.push_back({7'h40, 12'h000}); // released trap
        repeat (3) @(negedge MCLK);
        WEAK_DETECT_CONTROL = 1'h1;
        L2_TAG_UE = 1'h1;
        fin(10'h000, 7'h00, 12'h000, 12'h000); // ignored
        WEAK_DETECT_CONTROL = 1'h0;
        for (int i = 0; i < 3; i++)
        begin
            I1_FILL_VALID = 1'h1;
            I1_FILL_CLASS = cer_class_t'(4'h1 << i);
            I1_FILL_ID = 12'($urandom);
            fin(i == 2 ? 10'h100 : 10'h000, 7'h00, 12'h000, 12'h000); // refill parity
        end
        I1_FETCH_PERR = 1'h1;
        fin(10'h080, 7'h00, 12'h000, 12'h000); // line reread
        rid = 12'($urandom);
        I1_BAD_INSN_COMPLETE = 1'h1;
        I1_BAD_INSN_ID = rid;
        fin(10'h000, 7'h20, rid, 12'h000); // precise trap
        D1_CHECK_VALID = 1'h1;
        D1_CLASS = CER_CE;
        fin(10'h040, 7'h00, 12'h000, 12'h000); // silent fix
        for (int k = 0; k < 3; k++)
        begin
            D1_CHECK_VALID = 1'h1;
            D1_CLASS = CER_MARKED;
            D1_IS_WRITEBACK = (k == 0);
            D1_IS_DW_STORE = (k == 2);
            D1_MARK_ID = rid;
            fin(10'h000, k == 1 ? 7'h10 : 7'h00, rid, 12'h000);
        end
        D1_CHECK_VALID = 1'h1;
        D1_CLASS = CER_RAW;
        D1_IS_WRITEBACK = 1'h1;
        fin(10'h020, 7'h08, 12'h000, ERROR_IDENTIFIER_REGISTER); // raw on writeback
        D1_CHECK_VALID = 1'h1;
        D1_CLASS = CER_RAW;
        fin(10'h010, 7'h08, 12'h000, 12'h000); // forced writeback
        D1_CHECK_VALID = 1'h1;
        D1_CLASS = CER_RAW;
        D1_WAY_REDUCED = 1'h1;
        fin(10'h000, 7'h10, ERROR_IDENTIFIER_REGISTER, 12'h000); // after reduction
        L2_FILL_VALID = 1'h1;
        L2_FILL_CLASS = CER_CE;
        fin(10'h008, 7'h04, 12'h000, 12'h000); // incoming fix
        L2_FILL_VALID = 1'h1;
        L2_FILL_CLASS = CER_MARKED;
        fin(10'h000, 7'h00, 12'h000, 12'h000); // passes
        L2_FILL_VALID = 1'h1;
        L2_FILL_CLASS = CER_RAW;
        fin(10'h004, 7'h02, 12'h000, 12'h000); // id zero
        for (int p = 0; p < 3; p++)
            for (int j = 1; j < 4; j++)
            begin
                L2_READ_VALID = 1'h1;
                L2_READ_PATH = cer_path_t'(p);
                L2_READ_CLASS = cer_class_t'(4'h1 << j);
                fin(j == 1 ? 10'h002 : j == 3 ? 10'h001 : 10'h000,
                    (j == 3 && p == 2) ? 7'h01 : 7'h00, 12'h000,
                    ERROR_IDENTIFIER_REGISTER);
            end
        L1_TAG_PERR = 1'h1;
        fin(10'h000, 7'h00, 12'h000, 12'h000);
        chk(L1_TAG_COPY_REQ === 1'h1, "copy retry");
        for (int k = 0; k < 40 && L1_TAG_COPY_REQ !== 1'h0; k++)
            @(negedge MCLK);
        chk({L1_TAG_COPY_REQ, FATAL_ERROR} === 2'h0, "repaired");
        fails = 5'h1F;
        L1_TAG_PERR = 1'h1;
        fin(10'h000, 7'h00, 12'h000, 12'h000);
        repeat (40) @(negedge MCLK);
        chk(FATAL_ERROR === 1'h1, "permanent tag fault");
        rst();
        INTERNAL_MODE_REGISTER = 1'h1;
        L2_TAG_UE = 1'h1;
        fin(10'h000, 7'h00, 12'h000, 12'h000);
        chk(FATAL_ERROR === 1'h1, "fatal mode");
        chk(expq.size() == 0, "missing events");
        finish_test();
    end
endmodule
